/* File: design/core_seq_pkg.sv */
package core_seq_pkg;

  // ***********************************************
  // widths and fixed values
  // ***********************************************
  localparam int PC_W = 13;
  localparam int PAGE_W = 5;
  localparam int NUM_INPUTS = 20;
  localparam int NUM_AC = 6;
  localparam int NUM_MISC = 7;
  localparam int NUM_CFG = 21;
  localparam int IDX_W = 5;
  localparam logic [PC_W-1:0] RESET_VECTOR = 13'h0000;
  localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
  localparam logic [7:0] STACK_TOP = 8'hff;
  localparam logic [7:0] STACK_STEP = 8'h02;
  localparam logic [7:0] BYTE_STEP = 8'h01;
  localparam logic [4:0] IN_SP = 5'h00;
  localparam logic [4:0] IN_AC_BASE = 5'h01;
  localparam logic [4:0] IN_MISC_BASE = 5'h0d;

  // ***********************************************
  // register map
  // ***********************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PC = 8'h04;
  localparam logic [7:0] REG_STACK = 8'h08;
  localparam logic [7:0] REG_FLAGS = 8'h0c;
  localparam logic [7:0] REG_CFG_SEL = 8'h10;
  localparam logic [7:0] REG_CFG_DATA = 8'h14;
  localparam logic [7:0] REG_PAGE = 8'h18;
  localparam int RUN_BIT = 0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ***********************************************
  // operations and sections
  // ***********************************************
  typedef enum logic [3:0] {
    step_op, jump_op, call_op, subroutine_exit_op, interrupt_exit_op,
    irq_entry_op, arith_op, copy_input_to_ram_op, config_from_program_op,
    config_from_ram_op, decide_op
  } op_t;

  localparam int SEC_LOAD = 0;
  localparam int SEC_ARITH = 1;
  localparam int SEC_JUMP = 2;
  localparam int SEC_CONTROL = 3;
  localparam int SEC_DECIDE = 4;

  typedef enum logic [3:0] {
    st_idle, st_push_hi, st_push_lo, st_pop_a, st_pop_b, st_pop_c,
    st_pop_d, st_cfg_req, st_cfg_data
  } seq_state_t;

  function automatic logic [4:0] section_of(input op_t op);
    logic [4:0] s;
    s = 5'h00;
    unique case (op)
      copy_input_to_ram_op, config_from_program_op, config_from_ram_op: s[SEC_LOAD] = 1'b1;
      arith_op: s[SEC_ARITH] = 1'b1;
      jump_op, call_op, subroutine_exit_op: s[SEC_JUMP] = 1'b1;
      step_op, interrupt_exit_op, irq_entry_op: s[SEC_CONTROL] = 1'b1;
      decide_op: s[SEC_DECIDE] = 1'b1;
      default: s[SEC_CONTROL] = 1'b1;
    endcase
    return s;
  endfunction : section_of

endpackage : core_seq_pkg

/* File: design/flag_bank.sv */
`timescale 1ns/1ps
module flag_bank #(
  parameter int LEVELS = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enter,
  input wire logic leave,
  input wire logic upd,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic sub,
  output logic [7:0] result,
  output logic carry,
  output logic zero,
  output logic sign,
  output logic [$clog2(LEVELS+1)-1:0] level,
  output logic full
);
  localparam int LW = $clog2(LEVELS + 1);
  localparam logic [LW-1:0] LVL_ONE = LW'(1);
  localparam logic [LW-1:0] LVL_MAX = LW'(LEVELS);

  typedef struct packed {
    logic [LW-1:0] level;
    logic [LEVELS:0][2:0] sets;
  } bank_t;

  bank_t cur, next_cur;
  logic [8:0] wide;

  always_comb begin
    next_cur = cur;
    wide = sub ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
    result = wide[7:0];
    if (upd) begin
      // carry on overflow, sign on underflow, both cleared otherwise
      next_cur.sets[cur.level] = {!sub && wide[8], result == 8'h00, sub && wide[8]}; // [RULE_11] [RULE_12]
    end
    // sets are only selected, never cleared, on a switch
    if (enter && cur.level != LVL_MAX) begin
      next_cur.level = cur.level + LVL_ONE; // [RULE_06] [RULE_10] [RULE_23]
    end else if (leave && cur.level != '0) begin
      next_cur.level = cur.level - LVL_ONE; // [RULE_07] [RULE_08]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign {carry, zero, sign} = cur.sets[cur.level]; // [RULE_05]
  assign level = cur.level;
  assign full = (cur.level == LVL_MAX);
endmodule : flag_bank

/* File: design/input_bench.sv */
`timescale 1ns/1ps
module input_bench
  import core_seq_pkg::*;
#(
  parameter int AC_CH = NUM_AC,
  parameter int MISC_N = NUM_MISC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] sp,
  input wire logic [AC_CH-1:0][15:0] ac_value,
  input wire logic [MISC_N-1:0][7:0] misc_in,
  input wire logic [IDX_W-1:0] index,
  output logic [7:0] value
);
  typedef struct packed {
    logic [NUM_INPUTS-1:0][7:0] bench;
  } bench_t;

  bench_t cur, next_cur;

  always_comb begin
    next_cur = cur;
    next_cur.bench[IN_SP] = sp; // [RULE_19]
    for (int i = 0; i < AC_CH; i++) begin
      next_cur.bench[int'(IN_AC_BASE) + 2 * i] = ac_value[i][15:8];
      next_cur.bench[int'(IN_AC_BASE) + 2 * i + 1] = ac_value[i][7:0];
    end
    for (int j = 0; j < MISC_N; j++) begin
      next_cur.bench[int'(IN_MISC_BASE) + j] = misc_in[j];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // read only; out-of-range index reads zero
  assign value = (int'(index) < NUM_INPUTS) ? cur.bench[index] : 8'h00; // [RULE_18]
endmodule : input_bench

/* File: design/core_sequencer.sv */
`timescale 1ns/1ps
// Operation
// RULE_01: a 13-bit counter holds the next program fetch address.
// RULE_02: jumps and calls reach any of 8192 bytes directly, no paging.
// RULE_03: after each fetch the counter is incremented and written back.
// RULE_04: counter loads from exactly one source: jump, vector, pop, reset, or plus one.
// RULE_05: two flag sets, normal and interrupt, each carry, zero, sign; one visible. The code keeps IRQ_LEVELS+1 sets, one per level.
// RULE_06: taking an interrupt switches flag use to the interrupt set at once.
// RULE_07: each interrupt level keeps its own flag set, restored on interrupt return.
// RULE_08: returning to normal mode brings back the normal flags as they were.
// RULE_09: call and subroutine return are normal mode; flags untouched.
// RULE_10: flags are never cleared on a context switch.
// RULE_11: arithmetic sets carry on overflow, clears it otherwise.
// RULE_12: arithmetic sets sign on underflow, clears it otherwise.
// RULE_13: interrupt or call pushes the counter into RAM, two bytes per level.
// RULE_14: stack starts at RAM address 255 and grows downward.
// RULE_15: software keeps stack nesting below 128 levels.
// RULE_16: push moves each level one deeper and puts the counter on top.
// RULE_17: return moves the top level into the counter and shifts levels up.
// RULE_18: a read-only bench of 20 eight-bit input registers, indexed from zero.
// RULE_19: input 0 is stack pointer, next 12 comparator bytes, last 7 port/timer.
// RULE_20: copy-from-input writes the chosen input register into a RAM byte.
// RULE_21: 21 config registers load from program page or from RAM.
// RULE_22: arbitration activates exactly one of five sections per instruction.
// RULE_23: flag stack depth equals the number of nested interrupt levels.
module core_sequencer
  import core_seq_pkg::*;
#(
  parameter int IRQ_LEVELS = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic op_valid,
  output logic op_ready,
  input wire core_seq_pkg::op_t op_code,
  input wire logic [core_seq_pkg::PC_W-1:0] op_target,
  input wire logic [core_seq_pkg::IDX_W-1:0] op_index,
  input wire logic [7:0] op_mem,
  input wire logic [7:0] op_a,
  input wire logic [7:0] op_b,
  input wire logic op_sub,
  output logic [core_seq_pkg::PC_W-1:0] pm_addr,
  input wire logic [7:0] pm_rdata,
  output logic [7:0] ram_addr,
  output logic [7:0] ram_wdata,
  output logic ram_we,
  output logic ram_re,
  input wire logic [7:0] ram_rdata,
  input wire logic [core_seq_pkg::NUM_AC-1:0][15:0] ac_value,
  input wire logic [core_seq_pkg::NUM_MISC-1:0][7:0] misc_in,
  output logic [core_seq_pkg::NUM_CFG-1:0][7:0] cfg_regs,
  output logic [4:0] active_section,
  output logic carry,
  output logic zero,
  output logic sign
);
  localparam int LW = $clog2(IRQ_LEVELS + 1);

  // ***********************************************
  // state
  // ***********************************************
  typedef struct packed {
    seq_state_t state;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] pm_addr;
    logic [PC_W-1:0] push_val;
    logic [PC_W-1:0] jump_to;
    logic [7:0] sp;
    logic [7:0] ram_addr;
    logic [7:0] ram_wdata;
    logic ram_we;
    logic ram_re;
    logic [7:0] pop_lo;
    logic cfg_from_pm;
    logic [IDX_W-1:0] cfg_idx;
    logic [NUM_CFG-1:0][7:0] cfg;
    logic [4:0] section;
    logic run;
    logic [IDX_W-1:0] cfg_sel;
    logic [PAGE_W-1:0] page;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic w_lane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } core_t;

  core_t cur, next_cur;

  logic accept;
  logic flag_enter;
  logic flag_leave;
  logic flag_upd;
  logic [7:0] arith_result;
  logic [LW-1:0] irq_level;
  logic irq_full;
  logic [7:0] bench_value;
  logic [PC_W-1:0] pc_plus;
  logic [IDX_W-1:0] bench_index;

  // ***********************************************
  // helpers
  // ***********************************************
  flag_bank #(
    .LEVELS(IRQ_LEVELS)
  ) u_flags (
    .aclk(aclk),
    .aresetn(aresetn),
    .enter(flag_enter),
    .leave(flag_leave),
    .upd(flag_upd),
    .a(op_a),
    .b(op_b),
    .sub(op_sub),
    .result(arith_result),
    .carry(carry),
    .zero(zero),
    .sign(sign),
    .level(irq_level),
    .full(irq_full)
  );

  input_bench #(
    .AC_CH(NUM_AC),
    .MISC_N(NUM_MISC)
  ) u_bench (
    .aclk(aclk),
    .aresetn(aresetn),
    .sp(cur.sp),
    .ac_value(ac_value),
    .misc_in(misc_in),
    .index(bench_index),
    .value(bench_value)
  );

  assign bench_index = op_index;
  assign pc_plus = cur.pc + PC_STEP; // [RULE_03]

  // one operation at a time, only while running and idle
  assign op_ready = cur.run && (cur.state == st_idle) &&
                    !(op_code == irq_entry_op && irq_full);
  assign accept = op_valid && op_ready;
  assign flag_enter = accept && (op_code == irq_entry_op); // [RULE_06]
  assign flag_leave = accept && (op_code == interrupt_exit_op); // [RULE_07]
  assign flag_upd = accept && (op_code == arith_op);

  // ***********************************************
  // next state
  // ***********************************************
  always_comb begin
    next_cur = cur;
    next_cur.ram_we = 1'b0;
    next_cur.ram_re = 1'b0;
    next_cur.section = 5'h00;
    next_cur.pm_addr = cur.pc;

    unique case (cur.state)
      st_idle: begin
        if (accept) begin
          next_cur.section = section_of(op_code); // [RULE_22]
          unique case (op_code)
            jump_op: begin
              next_cur.pc = op_target; // [RULE_02] [RULE_04]
            end
            call_op, irq_entry_op: begin
              // call returns past itself; an interrupt resumes the fetch it displaced
              next_cur.push_val = (op_code == call_op) ? pc_plus : cur.pc; // [RULE_13]
              next_cur.jump_to = op_target;
              next_cur.ram_we = 1'b1;
              next_cur.ram_addr = cur.sp; // [RULE_14]
              next_cur.ram_wdata = 8'((op_code == call_op ? pc_plus : cur.pc) >> 8);
              next_cur.state = st_push_lo;
            end
            subroutine_exit_op, interrupt_exit_op: begin
              // flags handled only on interrupt exit
              next_cur.ram_re = 1'b1; // [RULE_09]
              next_cur.ram_addr = cur.sp + BYTE_STEP;
              next_cur.state = st_pop_a;
            end
            arith_op: begin
              next_cur.ram_we = 1'b1;
              next_cur.ram_addr = op_mem;
              next_cur.ram_wdata = arith_result;
              next_cur.pc = pc_plus;
            end
            copy_input_to_ram_op: begin
              next_cur.ram_we = 1'b1; // [RULE_20]
              next_cur.ram_addr = op_mem;
              next_cur.ram_wdata = bench_value;
              next_cur.pc = pc_plus;
            end
            config_from_program_op: begin
              next_cur.cfg_from_pm = 1'b1;
              next_cur.cfg_idx = op_index;
              next_cur.pm_addr = {cur.page, op_mem}; // [RULE_21]
              next_cur.pc = pc_plus;
              next_cur.state = st_cfg_req;
            end
            config_from_ram_op: begin
              next_cur.cfg_from_pm = 1'b0;
              next_cur.cfg_idx = op_index;
              next_cur.ram_re = 1'b1; // [RULE_21]
              next_cur.ram_addr = op_mem;
              next_cur.pc = pc_plus;
              next_cur.state = st_cfg_req;
            end
            default: begin
              next_cur.pc = pc_plus; // [RULE_04]
            end
          endcase
        end
      end
      st_push_lo: begin
        next_cur.ram_we = 1'b1; // [RULE_16]
        next_cur.ram_addr = cur.sp - BYTE_STEP;
        next_cur.ram_wdata = cur.push_val[7:0];
        next_cur.sp = cur.sp - STACK_STEP;
        next_cur.pc = cur.jump_to; // [RULE_04]
        next_cur.state = st_idle;
      end
      st_pop_a: begin
        next_cur.ram_re = 1'b1;
        next_cur.ram_addr = cur.sp + STACK_STEP;
        next_cur.state = st_pop_b;
      end
      st_pop_b: begin
        next_cur.pop_lo = ram_rdata;
        next_cur.state = st_pop_c;
      end
      st_pop_c: begin
        next_cur.pc = {ram_rdata[PC_W-9:0], cur.pop_lo}; // [RULE_17] [RULE_04]
        next_cur.sp = cur.sp + STACK_STEP;
        next_cur.state = st_pop_d;
      end
      st_pop_d: begin
        next_cur.state = st_idle;
      end
      st_cfg_req: begin
        if (cur.cfg_from_pm) begin
          next_cur.pm_addr = cur.pm_addr;
        end
        next_cur.state = st_cfg_data;
      end
      st_cfg_data: begin
        if (int'(cur.cfg_idx) < NUM_CFG) begin
          next_cur.cfg[cur.cfg_idx] = cur.cfg_from_pm ? pm_rdata : ram_rdata; // [RULE_21]
        end
        next_cur.state = st_idle;
      end
      default: begin
        next_cur.state = st_idle;
      end
    endcase

    // ***********************************************
    // register bus
    // ***********************************************
    if (s_axi_awvalid && s_axi_awready) begin
      next_cur.aw_held = 1'b1;
      next_cur.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_cur.w_held = 1'b1;
      next_cur.w_data = s_axi_wdata;
      next_cur.w_lane = s_axi_wstrb[0];
    end
    if (cur.aw_held && cur.w_held && !cur.bvalid) begin
      next_cur.aw_held = 1'b0;
      next_cur.w_held = 1'b0;
      next_cur.bvalid = 1'b1;
      next_cur.bresp = RESP_OKAY;
      unique case (cur.aw_addr)
        REG_CTRL: begin
          if (cur.w_lane) begin
            next_cur.run = cur.w_data[RUN_BIT];
          end
        end
        REG_CFG_SEL: begin
          if (cur.w_lane) begin
            next_cur.cfg_sel = cur.w_data[IDX_W-1:0];
          end
        end
        REG_PAGE: begin
          if (cur.w_lane) begin
            next_cur.page = cur.w_data[PAGE_W-1:0];
          end
        end
        REG_PC, REG_STACK, REG_FLAGS, REG_CFG_DATA: begin
          next_cur.bresp = RESP_OKAY;
        end
        default: begin
          next_cur.bresp = RESP_SLVERR;
        end
      endcase
    end else if (cur.bvalid && s_axi_bready) begin
      next_cur.bvalid = 1'b0;
    end

    if (s_axi_arvalid && s_axi_arready) begin
      next_cur.rvalid = 1'b1;
      next_cur.rresp = RESP_OKAY;
      next_cur.rdata = 32'h0000_0000;
      unique case (s_axi_araddr)
        REG_CTRL: next_cur.rdata[RUN_BIT] = cur.run;
        REG_PC: next_cur.rdata[PC_W-1:0] = cur.pc;
        REG_STACK: next_cur.rdata[7:0] = cur.sp;
        REG_FLAGS: next_cur.rdata[LW+2:0] = {irq_level, carry, zero, sign};
        REG_CFG_SEL: next_cur.rdata[IDX_W-1:0] = cur.cfg_sel;
        REG_CFG_DATA: begin
          if (int'(cur.cfg_sel) < NUM_CFG) begin
            next_cur.rdata[7:0] = cur.cfg[cur.cfg_sel];
          end
        end
        REG_PAGE: next_cur.rdata[PAGE_W-1:0] = cur.page;
        default: next_cur.rresp = RESP_SLVERR;
      endcase
    end else if (cur.rvalid && s_axi_rready) begin
      next_cur.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur <= '0;
      cur.state <= st_idle;
      cur.pc <= RESET_VECTOR; // [RULE_01] [RULE_04]
      cur.pm_addr <= RESET_VECTOR;
      cur.sp <= STACK_TOP; // [RULE_14]
    end else begin
      cur <= next_cur;
    end
  end

  // ***********************************************
  // outputs
  // ***********************************************
  assign s_axi_awready = !cur.aw_held && !cur.bvalid;
  assign s_axi_wready = !cur.w_held && !cur.bvalid;
  assign s_axi_bvalid = cur.bvalid;
  assign s_axi_bresp = cur.bresp;
  assign s_axi_arready = !cur.rvalid;
  assign s_axi_rvalid = cur.rvalid;
  assign s_axi_rresp = cur.rresp;
  assign s_axi_rdata = cur.rdata;
  assign pm_addr = cur.pm_addr;
  assign ram_addr = cur.ram_addr;
  assign ram_wdata = cur.ram_wdata;
  assign ram_we = cur.ram_we;
  assign ram_re = cur.ram_re;
  assign cfg_regs = cur.cfg;
  assign active_section = cur.section;
endmodule : core_sequencer

/* File: sim/mem_model.sv */
`timescale 1ns/1ps
module mem_model
  import core_seq_pkg::*;
(
  input wire logic aclk,
  input wire logic [core_seq_pkg::PC_W-1:0] pm_addr,
  output logic [7:0] pm_rdata,
  input wire logic [7:0] ram_addr,
  input wire logic [7:0] ram_wdata,
  input wire logic ram_we,
  input wire logic ram_re,
  output logic [7:0] ram_rdata
);
  // ****
  // program memory and data ram
  // ****
  logic [7:0] ram [256];

  always_ff @(posedge aclk) begin
    pm_rdata <= pm_addr[7:0] ^ {3'h0, pm_addr[12:8]};
    if (ram_we) begin
      ram[ram_addr] <= ram_wdata;
    end
    // idle bus shows no stale data
    ram_rdata <= ram_re ? ram[ram_addr] : ~(ram_addr ^ ram_wdata);
  end
endmodule : mem_model

/* File: sim/core_seq_asserts.sv */
`timescale 1ns/1ps
module core_seq_asserts
  import core_seq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic op_valid,
  input wire logic op_ready,
  input wire core_seq_pkg::op_t op_code,
  input wire logic [core_seq_pkg::PC_W-1:0] op_target,
  input wire logic [7:0] op_a,
  input wire logic [7:0] op_b,
  input wire logic op_sub,
  input wire logic [core_seq_pkg::PC_W-1:0] pm_addr,
  input wire logic [7:0] ram_addr,
  input wire logic ram_we,
  input wire logic ram_re,
  input wire logic [4:0] active_section,
  input wire logic carry,
  input wire logic zero,
  input wire logic sign
);
  // ****
  // checks
  // ****
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic acc;
  assign acc = op_valid && op_ready;

  sect_onehot_a: assert property (active_section != 5'h00 |-> $onehot(active_section))
    else $error("section not one-hot");
  sect_pulse_a: assert property (acc |=> $onehot(active_section))
    else $error("no section after op");
  sect_jump_a: assert property (acc && (op_code inside {jump_op, call_op, subroutine_exit_op})
    |=> active_section[SEC_JUMP])
    else $error("jump section not chosen");
  jump_pc_a: assert property (acc && op_code == jump_op
    |=> ##1 pm_addr == $past(op_target, 2))
    else $error("jump target not loaded");
  step_pc_a: assert property (acc && op_code == step_op
    |=> ##1 pm_addr == $past(pm_addr) + PC_STEP)
    else $error("counter not incremented");
  push_order_a: assert property (acc && op_code == call_op
    |=> ram_we ##1 (ram_we && ram_addr == $past(ram_addr) - BYTE_STEP))
    else $error("push bytes wrong");
  pop_order_a: assert property (acc && op_code == subroutine_exit_op
    |=> ram_re ##1 (ram_re && ram_addr == $past(ram_addr) + BYTE_STEP))
    else $error("pop bytes wrong");
  call_flags_a: assert property (acc && (op_code inside {call_op, subroutine_exit_op})
    |=> $stable({carry, zero, sign}) [*2])
    else $error("flags changed by call or return");
  add_carry_a: assert property (acc && op_code == arith_op && !op_sub
    |=> carry == $past(({1'b0, op_a} + {1'b0, op_b}) > 9'h0ff))
    else $error("carry wrong");
  sub_sign_a: assert property (acc && op_code == arith_op && op_sub
    |=> sign == $past(op_a < op_b))
    else $error("sign wrong");

  call_c: cover property (acc && op_code == call_op);
  irq_c: cover property (acc && op_code == irq_entry_op);
  interrupt_exit_op_c: cover property (acc && op_code == interrupt_exit_op);
endmodule : core_seq_asserts

bind core_sequencer core_seq_asserts u_chk (.aclk(aclk), .aresetn(aresetn),
  .op_valid(op_valid), .op_ready(op_ready), .op_code(op_code), .op_target(op_target),
  .op_a(op_a), .op_b(op_b), .op_sub(op_sub), .pm_addr(pm_addr), .ram_addr(ram_addr),
  .ram_we(ram_we), .ram_re(ram_re), .active_section(active_section), .carry(carry),
  .zero(zero), .sign(sign));

/* File: sim/core_pc_flags_stack_control_test.sv */
`timescale 1ns/1ps
module core_pc_flags_stack_control_test;
  import core_seq_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, op_mem, op_a, op_b, pm_rdata;
  logic [7:0] ram_addr, ram_wdata, ram_rdata;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
  logic op_valid, op_ready, op_sub, ram_we, ram_re, carry, zero, sign;
  op_t op_code;
  logic [PC_W-1:0] op_target, pm_addr;
  logic [IDX_W-1:0] op_index;
  logic [NUM_AC-1:0][15:0] ac_value;
  logic [NUM_MISC-1:0][7:0] misc_in;
  logic [NUM_CFG-1:0][7:0] cfg_regs;
  logic [4:0] active_section;
  logic [4:0] idx_tab [6] = '{5'h0, 5'h1, 5'h2, 5'h0d, 5'h13, 5'h14};
  logic [7:0] exp_tab [6] = '{8'hfd, 8'h12, 8'h34, 8'hc7, 8'h66, 8'h00};
  int err_total, n_checks;

  core_sequencer DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .op_valid, .op_ready, .op_code, .op_target,
    .op_index, .op_mem, .op_a, .op_b, .op_sub, .pm_addr, .pm_rdata, .ram_addr, .ram_wdata,
    .ram_we, .ram_re, .ram_rdata, .ac_value, .misc_in, .cfg_regs, .active_section, .carry,
    .zero, .sign);
  mem_model u_mem (.aclk, .pm_addr, .pm_rdata, .ram_addr, .ram_wdata, .ram_we, .ram_re,
    .ram_rdata);

  // ****
  // tasks
  // ****
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic hang;
    err_total++;
    $display("CHECK FAILED handshake exp done seen timeout");
    end_of_test();
  endtask : hang

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    if (s_axi_bvalid !== 1'b1) hang();
  endtask : axi_wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    if (s_axi_rvalid !== 1'b1) hang();
    last_resp = s_axi_rresp;
    chk($sformatf("reg %h", a), s_axi_rdata, e);
  endtask : rdc

  task automatic ramc(input logic [7:0] a, input logic [7:0] e);
    @(negedge aclk);
    chk($sformatf("ram %h", a), {24'h0, u_mem.ram[a]}, {24'h0, e});
  endtask : ramc

  task automatic do_op(input op_t c, input logic [PC_W-1:0] t, input logic [IDX_W-1:0] i,
      input logic [7:0] m, input logic [7:0] a, input logic [7:0] b, input logic s);
    int n;
    n = 0;
    @(posedge aclk);
    op_code <= c;
    op_target <= t;
    op_index <= i;
    op_mem <= m;
    op_a <= a;
    op_b <= b;
    op_sub <= s;
    op_valid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (op_ready !== 1'b1 && n < 50);
    op_valid <= 1'b0;
    if (op_ready !== 1'b1) hang();
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (op_ready !== 1'b1 && n < 50);
    if (op_ready !== 1'b1) hang();
  endtask : do_op

  // ****
  // scenarios
  // ****
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  initial begin
    logic [7:0] m;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    {op_valid, op_sub, op_target, op_index, op_mem, op_a, op_b} = 44'h0;
    op_code = step_op;
    ac_value = {16'hb0b1, 16'ha0a1, 16'h9091, 16'h8081, 16'h7071, 16'h1234};
    misc_in = {8'h66, 8'h55, 8'h44, 8'h33, 8'h22, 8'h11, 8'hc7};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(REG_PC, 32'h0);
    rdc(REG_STACK, 32'hff);
    rdc(REG_FLAGS, 32'h0);
    rdc(8'h40, 32'h0);
    chk("rresp", {30'h0, last_resp}, {30'h0, RESP_SLVERR});
    axi_wr(REG_CTRL, 32'h1);
    do_op(step_op, 13'h0, 5'h0, 8'h0, 8'h0, 8'h0, 1'b0);
    do_op(decide_op, 13'h0, 5'h0, 8'h0, 8'h0, 8'h0, 1'b0);
    rdc(REG_PC, 32'h2);
    do_op(jump_op, 13'h1ffe, 5'h0, 8'h0, 8'h0, 8'h0, 1'b0);
    rdc(REG_PC, 32'h1ffe);
    do_op(call_op, 13'h0123, 5'h0, 8'h0, 8'h0, 8'h0, 1'b0);
    ramc(8'hff, 8'h1f);
    ramc(8'hfe, 8'hff);
    // nesting well below 128
    do_op(call_op, 13'h0200, 5'h0, 8'h0, 8'h0, 8'h0, 1'b0);
    ramc(8'hfd, 8'h01);
    ramc(8'hfc, 8'h24);
    rdc(REG_STACK, 32'hfb);
    rdc(REG_PC, 32'h0200);
    do_op(arith_op, 13'h0, 5'h0, 8'h10, 8'hf0, 8'h20, 1'b0);
    ramc(8'h10, 8'h10);
    rdc(REG_FLAGS, 32'h04);
    do_op(subroutine_exit_op, 13'h0, 5'h0, 8'h0, 8'h0, 8'h0, 1'b0);
    rdc(REG_PC, 32'h0124);
    rdc(REG_STACK, 32'hfd);
    rdc(REG_FLAGS, 32'h04);
    do_op(irq_entry_op, 13'h0040, 5'h0, 8'h0, 8'h0, 8'h0, 1'b0);
    rdc(REG_FLAGS, 32'h08);
    rdc(REG_PC, 32'h0040);
    do_op(arith_op, 13'h0, 5'h0, 8'h11, 8'h10, 8'h20, 1'b1);
    ramc(8'h11, 8'hf0);
    rdc(REG_FLAGS, 32'h09);
    do_op(interrupt_exit_op, 13'h0, 5'h0, 8'h0, 8'h0, 8'h0, 1'b0);
    rdc(REG_FLAGS, 32'h04);
    rdc(REG_PC, 32'h0124);
    do_op(irq_entry_op, 13'h0040, 5'h0, 8'h0, 8'h0, 8'h0, 1'b0);
    rdc(REG_FLAGS, 32'h09);
    do_op(interrupt_exit_op, 13'h0, 5'h0, 8'h0, 8'h0, 8'h0, 1'b0);
    rdc(REG_STACK, 32'hfd);
    for (int k = 0; k < 6; k++) begin
      m = 8'h30 + 8'(k);
      do_op(copy_input_to_ram_op, 13'h0, idx_tab[k], m, 8'h0, 8'h0, 1'b0);
      ramc(m, exp_tab[k]);
    end
    axi_wr(REG_PAGE, 32'h2);
    do_op(config_from_program_op, 13'h0, 5'h14, 8'h05, 8'h0, 8'h0, 1'b0);
    chk("cfg 20", {24'h0, cfg_regs[20]}, 32'h07);
    do_op(config_from_ram_op, 13'h0, 5'h3, 8'h31, 8'h0, 8'h0, 1'b0);
    chk("cfg 3", {24'h0, cfg_regs[3]}, 32'h12);
    axi_wr(REG_CFG_SEL, 32'h3);
    rdc(REG_CFG_DATA, 32'h12);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(REG_PC, 32'h0);
    rdc(REG_STACK, 32'hff);
    end_of_test();
  end
endmodule : core_pc_flags_stack_control_test
